/* File: src/cafc_acceptance_filter.sv */
// Operation
// R01: A 4-bit target code of 1111 sends a hit to the receive FIFO, 0000 to 1110 to that dedicated buffer.
// R02: Each 16-bit target register packs four filters, highest filter in bits 15-12, lowest in bits 3-0.
// R03: A standard pattern in bits 15-5 matches only when every compared identifier bit agrees.
// R04: With type checking on, extended-select bit 3 set accepts only extended frames, clear only standard.
// R05: With type checking off, the extended-select bit is ignored.
// R06: All 18 extended pattern bits must agree; 17:16 sit in bits 1-0 of the first register, 15:0 in the second.
// R07: Bits 4 and 2 of the standard pattern register read as zero and ignore writes.
// R08: Mask source 00, 01, 10 pick mask sets 0, 1, 2; 11 applies no mask and compares every bit.
// R09: The mask source register for filters 0-7 holds filter 7 in bits 15-14 down to filter 0 in bits 1-0.
// R10: A mask bit of 1 compares that identifier bit, 0 makes it a don't-care.
// R11: The type-check bit belongs to the mask; when 0 either frame type matches on agreeing bits.
// R12: Only an enabled filter can ever hit.
// R13: Target and mask source fields clear at reset; patterns are undefined until software writes them.
// R14: A hit delivers the frame to the buffer or FIFO named by the hitting filter's target field.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cafc_cfg.svh"

module cafc_acceptance_filter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration held elsewhere in the controller
  input wire logic [15:0] filterAcceptEnable,
  input wire logic [31:0] lowFilterTargets,
  input wire logic [15:0] highFilterMaskSources,
  input wire logic [32:0] maskSidSets,
  input wire logic [53:0] maskEidSets,
  input wire logic [2:0] frameTypeCheckEnable,
  // Received frame, one-cycle strobe
  input wire logic frameValid,
  input wire logic frameExtended,
  input wire logic [10:0] frameSid,
  input wire logic [17:0] frameEid,
  // Delivery
  output logic hitValid,
  output logic [3:0] hitFilter,
  output cafc_pkg::cafc_target_t hitTarget,
  output logic hitToFifo
);

  // ****************************************
  // Storage
  // ****************************************
  logic [15:0] stdPattern [16];
  logic [15:0] extPattern [16];
  logic [15:0] filter_8_11_buffer_target_reg;
  logic [15:0] filter_12_15_buffer_target_reg;
  logic [15:0] filter_0_7_mask_source_reg;
  logic hitSeen_reg;
  logic [3:0] lastFilter_reg;
  logic [3:0] lastTarget_reg;

  // ****************************************
  // Bus slave state
  // ****************************************
  logic awHeld_reg;
  logic [11:0] awAddr_reg;
  logic wHeld_reg;
  logic [15:0] wData_reg;
  logic [1:0] wStrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [15:0] data,
                                            input logic [1:0] strb);
    laneMerge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // Write decode
  // ****************************************
  wire doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
  wire wAligned = awAddr_reg[1:0] == 2'b00;
  wire [3:0] wIdx = awAddr_reg[5:2];
  wire wIsTgt811 = awAddr_reg == `CAFC_ADDR_TGT_8_11;
  wire wIsTgt1215 = awAddr_reg == `CAFC_ADDR_TGT_12_15;
  wire wIsMskSrc = awAddr_reg == `CAFC_ADDR_MSK_SRC_0_7;
  wire wIsStatus = awAddr_reg == `CAFC_ADDR_HIT_STATUS;
  wire wIsStd = wAligned && awAddr_reg[11:6] == `CAFC_REGION_STD;
  wire wIsExt = wAligned && awAddr_reg[11:6] == `CAFC_REGION_EXT;
  wire wMapped = wIsTgt811 || wIsTgt1215 || wIsMskSrc || wIsStatus || wIsStd || wIsExt;

  // ****************************************
  // Read decode
  // ****************************************
  wire rdTake = s_axi_arvalid && s_axi_arready;
  wire rAligned = s_axi_araddr[1:0] == 2'b00;
  wire [3:0] rIdx = s_axi_araddr[5:2];
  wire rIsTgt811 = s_axi_araddr == `CAFC_ADDR_TGT_8_11;
  wire rIsTgt1215 = s_axi_araddr == `CAFC_ADDR_TGT_12_15;
  wire rIsMskSrc = s_axi_araddr == `CAFC_ADDR_MSK_SRC_0_7;
  wire rIsStatus = s_axi_araddr == `CAFC_ADDR_HIT_STATUS;
  wire rIsStd = rAligned && s_axi_araddr[11:6] == `CAFC_REGION_STD;
  wire rIsExt = rAligned && s_axi_araddr[11:6] == `CAFC_REGION_EXT;
  wire rMapped = rIsTgt811 || rIsTgt1215 || rIsMskSrc || rIsStatus || rIsStd || rIsExt;
  wire [15:0] statusWord = {7'h00, hitSeen_reg, lastFilter_reg, lastTarget_reg};
  wire [15:0] rdWord;

  // Unimplemented pattern bits are never stored, so they read as zero [R07]
  assign rdWord = rIsTgt811 ? filter_8_11_buffer_target_reg :
                  rIsTgt1215 ? filter_12_15_buffer_target_reg :
                  rIsMskSrc ? filter_0_7_mask_source_reg :
                  rIsStatus ? statusWord :
                  rIsStd ? (stdPattern[rIdx] & `CAFC_STD_WMASK) :
                  rIsExt ? extPattern[rIdx] : 16'h0000;

  assign s_axi_awready = !awHeld_reg && !bvalid_reg;
  assign s_axi_wready = !wHeld_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ****************************************
  // Write channel
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  // Upper half of the word is not stored, so its lanes are dropped
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 16'h0000;
      wStrb_reg <= 2'b00;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata[15:0];
      wStrb_reg <= s_axi_wstrb[1:0];
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `CAFC_RESP_OKAY;
    end else if (doWrite) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wMapped ? `CAFC_RESP_OKAY : `CAFC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `CAFC_RESP_OKAY;
    end else if (rdTake) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {16'h0000, rdWord};
      rresp_reg <= rMapped ? `CAFC_RESP_OKAY : `CAFC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      filter_8_11_buffer_target_reg <= `CAFC_TGT_RESET; // [R13]
      filter_12_15_buffer_target_reg <= `CAFC_TGT_RESET; // [R13]
      filter_0_7_mask_source_reg <= `CAFC_MSK_SRC_RESET; // [R13]
    end else if (doWrite) begin
      if (wIsTgt811) begin
        filter_8_11_buffer_target_reg <= laneMerge(filter_8_11_buffer_target_reg, wData_reg, wStrb_reg);
      end
      if (wIsTgt1215) begin
        filter_12_15_buffer_target_reg <= laneMerge(filter_12_15_buffer_target_reg, wData_reg, wStrb_reg);
      end
      if (wIsMskSrc) begin
        filter_0_7_mask_source_reg <= laneMerge(filter_0_7_mask_source_reg, wData_reg, wStrb_reg);
      end
    end
  end

  // Patterns carry no reset; software loads them before enabling a filter
  always_ff @(posedge ref_clk) begin
    if (doWrite && wIsStd) begin
      stdPattern[wIdx] <= laneMerge(stdPattern[wIdx], wData_reg, wStrb_reg) & `CAFC_STD_WMASK; // [R07]
    end
    if (doWrite && wIsExt) begin
      extPattern[wIdx] <= laneMerge(extPattern[wIdx], wData_reg, wStrb_reg); // [R06]
    end
  end

  // ****************************************
  // Matching
  // ****************************************
  wire [63:0] allTargets = {filter_12_15_buffer_target_reg, filter_8_11_buffer_target_reg,
                            lowFilterTargets}; // [R02]
  wire [31:0] allMaskSources = {highFilterMaskSources, filter_0_7_mask_source_reg}; // [R09]
  wire [15:0] hitVec;

  generate
    for (genvar n = 0; n < 16; n++) begin : g_filter
      cafc_filter_match u_match (
        .patStd(stdPattern[n]),
        .patExt(extPattern[n]),
        .enable(filterAcceptEnable[n]),
        .maskSrc(cafc_pkg::cafc_mask_src_t'(allMaskSources[2*n +: 2])),
        .maskSidSets(maskSidSets),
        .maskEidSets(maskEidSets),
        .maskTypeSets(frameTypeCheckEnable),
        .frameExtended(frameExtended),
        .frameSid(frameSid),
        .frameEid(frameEid),
        .hit(hitVec[n])
      );
    end
  endgenerate

  // Lowest-numbered hitting filter wins
  logic [3:0] winner;
  always_comb begin
    winner = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (hitVec[i]) begin
        winner = 4'(i);
      end
    end
  end

  wire anyHit = frameValid && (hitVec != 16'h0000);
  wire [3:0] winTarget = allTargets[{winner, 2'b00} +: 4];

  // ****************************************
  // Delivery
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hitValid <= 1'b0;
      hitFilter <= 4'h0;
      hitTarget <= 4'h0;
      hitToFifo <= 1'b0;
    end else begin
      hitValid <= anyHit; // [R14]
      if (anyHit) begin
        hitFilter <= winner;
        hitTarget <= winTarget; // [R14]
        hitToFifo <= winTarget == `CAFC_TARGET_FIFO; // [R01]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hitSeen_reg <= 1'b0;
      lastFilter_reg <= 4'h0;
      lastTarget_reg <= 4'h0;
    end else if (anyHit) begin
      hitSeen_reg <= 1'b1;
      lastFilter_reg <= winner;
      lastTarget_reg <= winTarget;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  property p_fifo_code;
    hitValid |-> (hitToFifo == (hitTarget == `CAFC_TARGET_FIFO));
  endproperty
  a_fifo_code: assert property (p_fifo_code) else $error("FIFO flag disagrees with target code"); // [R01]

  property p_target_pack;
    (doWrite && wIsTgt811 && wStrb_reg == 2'b11) |=> filter_8_11_buffer_target_reg == $past(wData_reg);
  endproperty
  a_target_pack: assert property (p_target_pack) else $error("Target register write not stored"); // [R02]

  property p_std_compare;
    (frameValid && allMaskSources[1:0] == 2'b11 &&
     frameSid != stdPattern[0][`CAFC_SID_HI:`CAFC_SID_LO]) |-> !hitVec[0];
  endproperty
  a_std_compare: assert property (p_std_compare) else $error("Filter 0 hit on differing identifier"); // [R03]

  property p_type_check;
    (frameValid && hitVec[0] && allMaskSources[1:0] == 2'b11) |->
      frameExtended == stdPattern[0][`CAFC_EXT_SEL_BIT];
  endproperty
  a_type_check: assert property (p_type_check) else $error("Filter 0 hit on wrong frame type"); // [R04]

  property p_unimpl_zero;
    (rdTake && rIsStd) |=> (rdata_reg[4] == 1'b0 && rdata_reg[2] == 1'b0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented pattern bit read as one"); // [R07]

  property p_disabled_silent;
    (frameValid && filterAcceptEnable == 16'h0000) |=> !hitValid;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent) else $error("Hit with every filter disabled"); // [R12]

  property p_reset_clear;
    @(posedge ref_clk) disable iff (1'b0)
    srst |=> (filter_8_11_buffer_target_reg == 16'h0000 && filter_12_15_buffer_target_reg == 16'h0000 &&
              filter_0_7_mask_source_reg == 16'h0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Fields not cleared by reset"); // [R13]

  property p_delivery;
    anyHit |=> (hitValid && hitFilter == $past(winner) && hitTarget == $past(winTarget));
  endproperty
  a_delivery: assert property (p_delivery) else $error("Hit not delivered to its target"); // [R14]

  property p_no_frame_no_hit;
    !frameValid |=> !hitValid;
  endproperty
  a_no_frame_no_hit: assert property (p_no_frame_no_hit) else $error("Hit without a frame"); // [R14]

endmodule
`default_nettype wire

/* File: shared/cafc_cfg.svh */
`ifndef CAFC_CFG_SVH
`define CAFC_CFG_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define CAFC_ADDR_TGT_8_11 12'h000
`define CAFC_ADDR_TGT_12_15 12'h004
`define CAFC_ADDR_MSK_SRC_0_7 12'h008
`define CAFC_ADDR_HIT_STATUS 12'h00c
`define CAFC_REGION_STD 6'h01
`define CAFC_REGION_EXT 6'h02

// ****************************************
// Field layout
// ****************************************
`define CAFC_SID_HI 15
`define CAFC_SID_LO 5
`define CAFC_EXT_SEL_BIT 3
`define CAFC_EID_HI_HI 1
`define CAFC_EID_HI_LO 0
`define CAFC_STD_WMASK 16'hffeb
`define CAFC_TARGET_FIFO 4'hf
`define CAFC_STAT_SEEN_BIT 8

// ****************************************
// Reset values and responses
// ****************************************
`define CAFC_TGT_RESET 16'h0000
`define CAFC_MSK_SRC_RESET 16'h0000
`define CAFC_RESP_OKAY 2'b00
`define CAFC_RESP_SLVERR 2'b10

`endif

/* File: shared/cafc_pkg.sv */
`default_nettype none
package cafc_pkg;

  typedef enum logic [1:0] {
    MASK_SET0 = 2'b00,
    MASK_SET1 = 2'b01,
    MASK_SET2 = 2'b10,
    MASK_NONE = 2'b11
  } cafc_mask_src_t;

  typedef logic [3:0] cafc_target_t;

endpackage
`default_nettype wire

/* File: src/cafc_filter_match.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cafc_cfg.svh"

module cafc_filter_match (
  // Filter configuration
  input wire logic [15:0] patStd,
  input wire logic [15:0] patExt,
  input wire logic enable,
  input wire cafc_pkg::cafc_mask_src_t maskSrc,
  // Mask sets 0 to 2, set 0 lowest
  input wire logic [32:0] maskSidSets,
  input wire logic [53:0] maskEidSets,
  input wire logic [2:0] maskTypeSets,
  // Received frame
  input wire logic frameExtended,
  input wire logic [10:0] frameSid,
  input wire logic [17:0] frameEid,
  // Result
  output logic hit
);

  wire noMask = maskSrc == cafc_pkg::MASK_NONE;
  wire useSet2 = maskSrc == cafc_pkg::MASK_SET2;
  wire useSet1 = maskSrc == cafc_pkg::MASK_SET1;
  wire [10:0] selSid;
  wire [17:0] selEid;
  wire selType;
  wire sidOk;
  wire eidOk;
  wire typeOk;

  // No mask compares every bit and checks frame type [R08]
  assign selSid = noMask ? 11'h7ff : useSet2 ? maskSidSets[32:22] :
                  useSet1 ? maskSidSets[21:11] : maskSidSets[10:0];
  assign selEid = noMask ? 18'h3ffff : useSet2 ? maskEidSets[53:36] :
                  useSet1 ? maskEidSets[35:18] : maskEidSets[17:0];
  assign selType = noMask ? 1'b1 : useSet2 ? maskTypeSets[2] :
                   useSet1 ? maskTypeSets[1] : maskTypeSets[0];

  // Mask 1 compares the bit, 0 makes it a don't-care [R10]
  assign sidOk = ((frameSid ^ patStd[`CAFC_SID_HI:`CAFC_SID_LO]) & selSid) == 11'h000; // [R03]
  assign eidOk = ((frameEid ^ {patStd[`CAFC_EID_HI_HI:`CAFC_EID_HI_LO], patExt}) & selEid) == 18'h00000; // [R06]
  // Type bit only counts while type checking is on [R04] [R05] [R11]
  assign typeOk = !selType || (patStd[`CAFC_EXT_SEL_BIT] == frameExtended);
  assign hit = enable && sidOk && (!frameExtended || eidOk) && typeOk; // [R12]

endmodule
`default_nettype wire

/* File: tb/cafc_frame_source.sv */
`timescale 1ns/100ps
`default_nettype none

module cafc_frame_source (
  // Clock
  input wire logic ref_clk,
  // Received frame identifier towards the filter
  output logic frameValid,
  output logic frameExtended,
  output logic [10:0] frameSid,
  output logic [17:0] frameEid
);
  initial begin
    frameValid = 1'b0;
    frameExtended = 1'b0;
    frameSid = 11'h000;
    frameEid = 18'h00000;
  end

  // Identifier lines are inverted outside the strobe, so a stale value never matches by luck
  task automatic send(input logic ext, input logic [10:0] sid, input logic [17:0] eid);
    @(posedge ref_clk);
    {frameValid, frameExtended, frameSid, frameEid} <= {1'b1, ext, sid, eid};
    @(posedge ref_clk);
    {frameValid, frameExtended, frameSid, frameEid} <= {1'b0, ~ext, ~sid, ~eid};
  endtask
endmodule

`default_nettype wire

/* File: tb/test_can_acceptance_filter_config.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cafc_cfg.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, (ex), (got)); end end

module test_can_acceptance_filter_config;
  // ****************************************
  // Signals and shadow state
  // ****************************************
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] awAddr = 12'h000;
  logic [11:0] arAddr = 12'h000;
  logic [31:0] wData = 32'h00000000;
  logic [3:0] wStrb = 4'h3;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, hitValid, hitToFifo;
  logic [1:0] bResp, rResp, r;
  logic [31:0] rData, d;
  logic [3:0] hitFilter;
  cafc_pkg::cafc_target_t hitTarget;
  logic [15:0] filterAcceptEnable = 16'h0000;
  logic [31:0] lowFilterTargets = 32'h00000000;
  logic [15:0] highFilterMaskSources = 16'h0000;
  logic [32:0] maskSidSets = 33'h000000000;
  logic [53:0] maskEidSets = 54'h00000000000000;
  logic [2:0] frameTypeCheckEnable = 3'h0;
  logic frameValid, frameExtended, fExt;
  logic [10:0] frameSid, fSid;
  logic [17:0] frameEid, fEid;
  logic [15:0] stdPat [16];
  logic [15:0] extPat [16];
  logic [15:0] tgt811 = 16'h0000, tgt1215 = 16'h0000, msk07 = 16'h0000, v;
  logic [11:0] cfgAddr [3] = '{`CAFC_ADDR_TGT_8_11, `CAFC_ADDR_TGT_12_15, `CAFC_ADDR_MSK_SRC_0_7};
  int k;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #20 ref_clk = ~ref_clk;

  cafc_acceptance_filter dut (
    .ref_clk(ref_clk), .srst(srst),
    .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .filterAcceptEnable(filterAcceptEnable), .lowFilterTargets(lowFilterTargets),
    .highFilterMaskSources(highFilterMaskSources), .maskSidSets(maskSidSets), .maskEidSets(maskEidSets),
    .frameTypeCheckEnable(frameTypeCheckEnable), .frameValid(frameValid), .frameExtended(frameExtended),
    .frameSid(frameSid), .frameEid(frameEid), .hitValid(hitValid), .hitFilter(hitFilter),
    .hitTarget(hitTarget), .hitToFifo(hitToFifo)
  );

  cafc_frame_source src (
    .ref_clk(ref_clk), .frameValid(frameValid), .frameExtended(frameExtended),
    .frameSid(frameSid), .frameEid(frameEid)
  );

  // ****************************************
  // Bus tasks and reference
  // ****************************************
  task automatic axiWrite(input logic [11:0] a, input logic [15:0] dat, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge ref_clk);
    {awAddr, awValid, wData, wValid, bReady} <= {a, 1'b1, 16'h0000, dat, 1'b1, 1'b1};
    while (!done) begin
      @(posedge ref_clk);
      if (awValid && awReady) begin
        awValid <= 1'b0;
      end
      if (wValid && wReady) begin
        wValid <= 1'b0;
      end
      if (bValid && bReady) begin
        resp = bResp;
        bReady <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge ref_clk);
    {arAddr, arValid, rReady} <= {a, 1'b1, 1'b1};
    while (!done) begin
      @(posedge ref_clk);
      if (arValid && arReady) begin
        arValid <= 1'b0;
      end
      if (rValid && rReady) begin
        dat = rData;
        resp = rResp;
        rReady <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic writeCfg(input int sel, input logic [15:0] dat);
    logic [1:0] resp;
    axiWrite(cfgAddr[sel], dat, resp);
    `CHK("bresp", 2'b00, resp)
    if (sel == 0) tgt811 = dat;
    else if (sel == 1) tgt1215 = dat;
    else msk07 = dat;
  endtask

  // Lowest filter wins, so scan downwards and keep the last hit
  function automatic void predict(input logic ext, input logic [10:0] sid, input logic [17:0] eid,
                                  output logic found, output logic [3:0] filt, output logic [3:0] tgt);
    logic [1:0] sel;
    logic [10:0] sm;
    logic [17:0] em;
    logic tc;
    found = 1'b0;
    filt = 4'h0;
    tgt = 4'h0;
    for (int n = 15; n >= 0; n--) begin
      sel = (n < 8) ? msk07[2*n+:2] : highFilterMaskSources[2*(n-8)+:2];
      sm = (sel == 2'b11) ? 11'h7ff : maskSidSets[11*sel+:11];
      em = (sel == 2'b11) ? 18'h3ffff : maskEidSets[18*sel+:18];
      tc = (sel == 2'b11) ? 1'b1 : frameTypeCheckEnable[sel];
      if (filterAcceptEnable[n] && (((sid ^ stdPat[n][15:5]) & sm) == 11'h000)
          && (!ext || (((eid ^ {stdPat[n][1:0], extPat[n]}) & em) == 18'h00000))
          && (!tc || stdPat[n][3] == ext)) begin
        found = 1'b1;
        filt = 4'(n);
        tgt = (n < 8) ? lowFilterTargets[4*n+:4] : (n < 12) ? tgt811[4*(n-8)+:4] : tgt1215[4*(n-12)+:4];
      end
    end
  endfunction

  task automatic checkFrame(input logic ext, input logic [10:0] sid, input logic [17:0] eid);
    logic found;
    logic [3:0] filt, tgt;
    src.send(ext, sid, eid);
    predict(ext, sid, eid, found, filt, tgt);
    #1;
    `CHK("hitValid", found, hitValid)
    if (found) begin
      `CHK("hitFilter", filt, hitFilter)
      `CHK("hitTarget", tgt, hitTarget)
      `CHK("hitToFifo", tgt == 4'hf, hitToFifo)
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(32'h066cc91b));
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      axiRead(cfgAddr[s], d, r);
      `CHK("resetValue", 32'h00000000, d)
    end
    axiRead(12'h100, d, r);
    `CHK("unmappedRresp", 2'b10, r)
    axiWrite(12'h100, 16'hffff, r);
    `CHK("unmappedBresp", 2'b10, r)
    $display("test reset_values done");
    for (int n = 0; n < 16; n++) begin
      v = 16'($urandom);
      axiWrite(12'h040 + 12'(4 * n), v, r);
      stdPat[n] = v & 16'hffeb;
      extPat[n] = 16'($urandom);
      axiWrite(12'h080 + 12'(4 * n), extPat[n], r);
      axiRead(12'h040 + 12'(4 * n), d, r);
      `CHK("stdPattern", {16'h0000, stdPat[n]}, d)
      axiRead(12'h080 + 12'(4 * n), d, r);
      `CHK("extPattern", {16'h0000, extPat[n]}, d)
    end
    for (int s = 0; s < 3; s++) begin
      writeCfg(s, 16'($urandom));
      axiRead(cfgAddr[s], d, r);
      `CHK("configReg", {16'h0000, (s == 0) ? tgt811 : (s == 1) ? tgt1215 : msk07}, d)
    end
    // Low lane only: filters 12 and 13 change, 14 and 15 keep their codes
    v = ~tgt1215;
    @(posedge ref_clk);
    wStrb <= 4'h1;
    axiWrite(`CAFC_ADDR_TGT_12_15, v, r);
    wStrb <= 4'h3;
    tgt1215 = {tgt1215[15:8], v[7:0]};
    axiRead(`CAFC_ADDR_TGT_12_15, d, r);
    `CHK("byteLane", {16'h0000, tgt1215}, d)
    $display("test registers done");
    // Mask sets 0 to 2 are all don't-care and the frame copies filter 3, so only the enables keep every filter quiet
    checkFrame(stdPat[3][3], stdPat[3][15:5], {stdPat[3][1:0], extPat[3]});
    $display("test disabled_filter done");
    @(posedge ref_clk);
    filterAcceptEnable <= 16'h0100;
    highFilterMaskSources <= 16'h0003;
    for (int c = 0; c < 16; c++) begin
      writeCfg(0, {tgt811[15:4], 4'(c)});
      checkFrame(stdPat[8][3], stdPat[8][15:5], {stdPat[8][1:0], extPat[8]});
    end
    axiRead(`CAFC_ADDR_HIT_STATUS, d, r);
    `CHK("hitStatus", 32'h0000018f, d)
    $display("test target_codes done");
    repeat (300) begin
      @(posedge ref_clk);
      filterAcceptEnable <= 16'($urandom);
      lowFilterTargets <= $urandom;
      highFilterMaskSources <= 16'($urandom);
      maskSidSets <= 33'({$urandom, $urandom});
      maskEidSets <= 54'({$urandom, $urandom});
      frameTypeCheckEnable <= 3'($urandom);
      if ($urandom % 8 == 0) writeCfg($urandom % 3, 16'($urandom));
      k = $urandom % 16;
      fExt = ($urandom % 4 == 0) ? ~stdPat[k][3] : stdPat[k][3];
      fSid = stdPat[k][15:5] ^ (($urandom % 3 == 0) ? 11'(1 << ($urandom % 11)) : 11'h000);
      fEid = {stdPat[k][1:0], extPat[k]} ^ (($urandom % 3 == 0) ? 18'(1 << ($urandom % 18)) : 18'h00000);
      checkFrame(fExt, fSid, fEid);
    end
    $display("test random_frames done");
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      axiRead(cfgAddr[s], d, r);
      `CHK("midResetValue", 32'h00000000, d)
    end
    $display("test mid_reset done");
    conclude();
  end
endmodule

`default_nettype wire
